// ---- hw/fsp_pkg.sv ----
// Shared constants and helpers for the flash sector protection control.
// Assumes a 16-bit program memory address space and one bus clock.
package fsp_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] FSP_OFS_PROT = 8'h00;
    localparam logic [7:0] FSP_OFS_STATUS = 8'h04;
    localparam logic [7:0] FSP_OFS_CLEAR = 8'h08;
    localparam logic [7:0] FSP_OFS_ENABLE = 8'h0C;

    // ----------------------------------------
    // Protection setting fields
    // ----------------------------------------
    localparam int FSP_POL_BIT = 7;
    localparam int FSP_SPARE_BIT = 6;
    localparam int FSP_HDIS_BIT = 5;
    localparam int FSP_HSZ_MSB = 4;
    localparam int FSP_HSZ_LSB = 3;
    localparam int FSP_LDIS_BIT = 2;
    localparam int FSP_LSZ_MSB = 1;
    localparam int FSP_LSZ_LSB = 0;
    // Erased state: no protection until the stored byte arrives
    localparam logic [7:0] FSP_PROT_RST = 8'hFF;

    // ----------------------------------------
    // Status and interrupt bits
    // ----------------------------------------
    localparam int FSP_EVT_W = 2;
    localparam int FSP_EVT_VIOL = 0;
    localparam int FSP_EVT_REJECT = 1;
    localparam logic [FSP_EVT_W-1:0] FSP_EVT_RST = 2'h0;

    // ----------------------------------------
    // Array addresses and windows
    // ----------------------------------------
    localparam logic [15:0] FSP_NV_ADDR = 16'hFF0D;
    localparam logic [15:0] FSP_HIGH_BASE0 = 16'hF800;
    localparam logic [15:0] FSP_HIGH_BASE1 = 16'hF000;
    localparam logic [15:0] FSP_HIGH_BASE2 = 16'hE000;
    localparam logic [15:0] FSP_HIGH_BASE3 = 16'hC000;
    localparam logic [15:0] FSP_LOW_BASE = 16'h4000;
    localparam logic [15:0] FSP_LOW_END0 = 16'h41FF;
    localparam logic [15:0] FSP_LOW_END1 = 16'h43FF;
    localparam logic [15:0] FSP_LOW_END2 = 16'h47FF;
    localparam logic [15:0] FSP_LOW_END3 = 16'h4FFF;

    // Row r, bit c set: scenario r may move to scenario c
    localparam logic [63:0] FSP_SCEN_ALLOWED = 64'hFF5A_3C18_080C_0A0F;
    localparam logic [2:0] FSP_SCEN_OPEN = 3'h7;

    typedef enum logic [1:0] {FSP_LOAD_REQ, FSP_LOAD_WAIT, FSP_RUN} fsp_load_t;

    function automatic logic [2:0] fsp_scen(input logic [7:0] s);
        fsp_scen = {s[FSP_POL_BIT], s[FSP_HDIS_BIT], s[FSP_LDIS_BIT]};
    endfunction

    function automatic logic fsp_scen_ok(input logic [2:0] from, input logic [2:0] to);
        fsp_scen_ok = FSP_SCEN_ALLOWED[{from, to}];
    endfunction

endpackage

// ---- hw/fsp_prot_if.sv ----
// Carries the protection setting in force from its owner to its users.
// Assumes one clock domain; the owner drives, every user only reads.
`timescale 1ns/1ps
interface fsp_prot_if;
    logic [7:0] setting;
    modport owner (output setting);
    modport user (input setting);
endinterface

// ---- hw/fsp_scen_guard.sv ----
// Builds the value a register write would produce and judges the move.
// Assumes the setting in force arrives over the protection interface.
`timescale 1ns/1ps
module fsp_scen_guard
    import fsp_pkg::*;
(
    fsp_prot_if.user prot,
    input wire logic [7:0] wrData,
    output logic [7:0] nextSetting,
    output logic accept
);
    import fsp_pkg::*;

    wire logic [7:0] cur = prot.setting;
    // Polarity may only be cleared, never set again
    wire logic polNext = cur[FSP_POL_BIT] & wrData[FSP_POL_BIT];
    // Sizes are frozen while their window is enabled
    wire logic [1:0] hszNext = cur[FSP_HDIS_BIT] ? wrData[FSP_HSZ_MSB:FSP_HSZ_LSB]
                                                 : cur[FSP_HSZ_MSB:FSP_HSZ_LSB];
    wire logic [1:0] lszNext = cur[FSP_LDIS_BIT] ? wrData[FSP_LSZ_MSB:FSP_LSZ_LSB]
                                                 : cur[FSP_LSZ_MSB:FSP_LSZ_LSB];

    assign nextSetting = {polNext, wrData[FSP_SPARE_BIT], wrData[FSP_HDIS_BIT], hszNext,
                          wrData[FSP_LDIS_BIT], lszNext};
    assign accept = fsp_scen_ok(fsp_scen(cur), fsp_scen(nextSetting));
endmodule

// ---- hw/fsp_addr_check.sv ----
// Checks program and erase requests against the protection in force.
// Assumes requests are one-cycle strobes; answers one cycle later.
`timescale 1ns/1ps
module fsp_addr_check
    import fsp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    fsp_prot_if.user prot,
    input wire logic cmdValid,
    input wire logic cmdMassErase,
    input wire logic [15:0] cmdAddr,
    output logic violPulse
);
    import fsp_pkg::*;

    wire logic [7:0] s = prot.setting;
    wire logic [1:0] hsz = s[FSP_HSZ_MSB:FSP_HSZ_LSB];
    wire logic [1:0] lsz = s[FSP_LSZ_MSB:FSP_LSZ_LSB];
    wire logic [15:0] highBase = (hsz == 2'h0) ? FSP_HIGH_BASE0 :
                                 (hsz == 2'h1) ? FSP_HIGH_BASE1 :
                                 (hsz == 2'h2) ? FSP_HIGH_BASE2 : FSP_HIGH_BASE3;
    wire logic [15:0] lowEnd = (lsz == 2'h0) ? FSP_LOW_END0 :
                               (lsz == 2'h1) ? FSP_LOW_END1 :
                               (lsz == 2'h2) ? FSP_LOW_END2 : FSP_LOW_END3;
    wire logic inHigh = !s[FSP_HDIS_BIT] && (cmdAddr >= highBase);
    wire logic inLow = !s[FSP_LDIS_BIT] && (cmdAddr >= FSP_LOW_BASE)
                       && (cmdAddr <= lowEnd);
    wire logic inWindow = inHigh || inLow;
    // Polarity set: windows are protected; cleared: windows are the only open part
    wire logic addrProt = s[FSP_POL_BIT] ? inWindow : !inWindow;
    wire logic anyProt = fsp_scen(s) != FSP_SCEN_OPEN;
    wire logic violD = cmdValid && (cmdMassErase ? anyProt : addrProt);

    logic violQ;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            violQ <= 1'b0;
        end else begin
            violQ <= violD;
        end
    end
    assign violPulse = violQ;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_full_array;
        @(posedge ref_clk) disable iff (!rstn)
        cmdValid && !s[FSP_POL_BIT] && s[FSP_HDIS_BIT] && s[FSP_LDIS_BIT] |=> violPulse;
    endproperty
    a_full_array: assert property (p_full_array) else $error("Full array not protected");

    property p_open_array;
        @(posedge ref_clk) disable iff (!rstn)
        cmdValid && !cmdMassErase && (fsp_scen(s) == FSP_SCEN_OPEN) |=> !violPulse;
    endproperty
    a_open_array: assert property (p_open_array) else $error("Open array flagged");
endmodule

// ---- hw/fsp_top.sv ----
// Flash sector protection control: protection setting, address checks,
// violation status and interrupt, reached over a classic Wishbone slave.
// Assumes a synchronous array read port that returns the stored byte once.
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module fsp_top
    import fsp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic nvReq,
    output logic [15:0] nvAddr,
    input wire logic [7:0] nvData,
    input wire logic nvValid,
    input wire logic cmdValid,
    input wire logic cmdMassErase,
    input wire logic [15:0] cmdAddr,
    output logic protViolation,
    output logic irq
);
    import fsp_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    fsp_load_t load_q;
    fsp_load_t load_d;
    logic [7:0] setting_q;
    logic [7:0] setting_d;
    logic [FSP_EVT_W-1:0] status_q;
    logic [FSP_EVT_W-1:0] status_d;
    logic [FSP_EVT_W-1:0] enable_q;
    logic [FSP_EVT_W-1:0] enable_d;
    logic ack_q;
    logic [31:0] rdData_q;
    logic [31:0] rdData_d;
    logic irq_q;
    logic nvReq_q;
    logic nvReq_d;

    fsp_prot_if protIf ();
    assign protIf.setting = setting_q;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire logic busReq = wb_cyc_i && wb_stb_i && !ack_q;
    wire logic busWr = busReq && wb_we_i && wb_sel_i[0];
    wire logic selProt = (wb_adr_i == FSP_OFS_PROT);
    wire logic selStatus = (wb_adr_i == FSP_OFS_STATUS);
    wire logic selClear = (wb_adr_i == FSP_OFS_CLEAR);
    wire logic selEnable = (wb_adr_i == FSP_OFS_ENABLE);
    wire logic running = (load_q == FSP_RUN);
    // Writes before the stored byte arrives would be overwritten, so drop them
    wire logic wrProt = busWr && selProt && running;
    wire logic wrClear = busWr && selClear;
    wire logic wrEnable = busWr && selEnable;

    // ----------------------------------------
    // Write judgement and address checking
    // ----------------------------------------
    logic [7:0] guardNext;
    logic guardAccept;
    logic violPulse;

    fsp_scen_guard u_guard (
        .prot(protIf.user),
        .wrData(wb_dat_i[7:0]),
        .nextSetting(guardNext),
        .accept(guardAccept)
    );

    fsp_addr_check u_check (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .prot(protIf.user),
        .cmdValid(cmdValid),
        .cmdMassErase(cmdMassErase),
        .cmdAddr(cmdAddr),
        .violPulse(violPulse)
    );

    wire logic wrReject = wrProt && !guardAccept;

    // ----------------------------------------
    // Reset-time load of the stored setting
    // ----------------------------------------
    always_comb begin
        load_d = load_q;
        nvReq_d = 1'b0;
        case (load_q)
            FSP_LOAD_REQ: begin
                nvReq_d = 1'b1;
                load_d = FSP_LOAD_WAIT;
            end
            FSP_LOAD_WAIT: begin
                nvReq_d = !nvValid;
                if (nvValid) begin
                    load_d = FSP_RUN;
                end
            end
            default: begin
                load_d = FSP_RUN;
            end
        endcase
    end

    // Setting: stored byte once, then only accepted writes
    always_comb begin
        setting_d = setting_q;
        if (load_q == FSP_LOAD_WAIT && nvValid) begin
            setting_d = nvData;
        end else if (wrProt && guardAccept) begin
            setting_d = guardNext;
        end
    end

    // ----------------------------------------
    // Status, enable and interrupt
    // ----------------------------------------
    wire logic [FSP_EVT_W-1:0] events = {wrReject, violPulse};
    wire logic [FSP_EVT_W-1:0] clearMask = wrClear ? wb_dat_i[FSP_EVT_W-1:0] : FSP_EVT_RST;

    // A new event beats a clear landing in the same cycle
    assign status_d = (status_q & ~clearMask) | events;
    assign enable_d = wrEnable ? wb_dat_i[FSP_EVT_W-1:0] : enable_q;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb begin
        rdData_d = 32'h0000_0000;
        if (selProt) begin
            rdData_d[7:0] = setting_q;
        end else if (selStatus) begin
            rdData_d[FSP_EVT_W-1:0] = status_q;
        end else if (selEnable) begin
            rdData_d[FSP_EVT_W-1:0] = enable_q;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            load_q <= FSP_LOAD_REQ;
            nvReq_q <= 1'b0;
            setting_q <= FSP_PROT_RST;
        end else begin
            load_q <= load_d;
            nvReq_q <= nvReq_d;
            setting_q <= setting_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            status_q <= FSP_EVT_RST;
            enable_q <= FSP_EVT_RST;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            enable_q <= enable_d;
            irq_q <= |(status_d & enable_d);
        end
    end

    // Every access, mapped or not, is answered one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            rdData_q <= 32'h0000_0000;
        end else begin
            ack_q <= busReq;
            rdData_q <= busReq ? rdData_d : rdData_q;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdData_q;
    assign nvReq = nvReq_q;
    // Fixed address, kept as a constant so it is a flop output in effect
    assign nvAddr = FSP_NV_ADDR;
    assign protViolation = status_q[FSP_EVT_VIOL];
    assign irq = irq_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    logic [2:0] scenPrev_q;
    logic ranPrev_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            scenPrev_q <= 3'h0;
            ranPrev_q <= 1'b0;
        end else begin
            scenPrev_q <= fsp_scen(setting_q);
            ranPrev_q <= running;
        end
    end

    property p_pol_only_clears;
        @(posedge ref_clk) disable iff (!rstn)
        ranPrev_q && running |-> !$rose(setting_q[FSP_POL_BIT]);
    endproperty
    a_pol_only_clears: assert property (p_pol_only_clears) else $error("Polarity set again");

    property p_hsz_lock;
        @(posedge ref_clk) disable iff (!rstn)
        ranPrev_q && $changed(setting_q[FSP_HSZ_MSB:FSP_HSZ_LSB])
            |-> $past(setting_q[FSP_HDIS_BIT]);
    endproperty
    a_hsz_lock: assert property (p_hsz_lock) else $error("High size changed while locked");

    property p_lsz_lock;
        @(posedge ref_clk) disable iff (!rstn)
        ranPrev_q && $changed(setting_q[FSP_LSZ_MSB:FSP_LSZ_LSB])
            |-> $past(setting_q[FSP_LDIS_BIT]);
    endproperty
    a_lsz_lock: assert property (p_lsz_lock) else $error("Low size changed while locked");

    property p_legal_move;
        @(posedge ref_clk) disable iff (!rstn)
        ranPrev_q |-> fsp_scen_ok(scenPrev_q, fsp_scen(setting_q));
    endproperty
    a_legal_move: assert property (p_legal_move) else $error("Illegal scenario move");

    property p_reject_hold;
        @(posedge ref_clk) disable iff (!rstn)
        wrReject |=> $stable(setting_q) && status_q[FSP_EVT_REJECT];
    endproperty
    a_reject_hold: assert property (p_reject_hold) else $error("Rejected write changed setting");

    property p_viol_flag;
        @(posedge ref_clk) disable iff (!rstn)
        violPulse |=> protViolation ##1 (protViolation || $past(wrClear));
    endproperty
    a_viol_flag: assert property (p_viol_flag) else $error("Violation not flagged");

    property p_read_setting;
        @(posedge ref_clk) disable iff (!rstn)
        busReq && !wb_we_i && selProt |=> wb_ack_o && (wb_dat_o[7:0] == $past(setting_q));
    endproperty
    a_read_setting: assert property (p_read_setting) else $error("Read not setting in force");

    property p_load_byte;
        @(posedge ref_clk) disable iff (!rstn)
        (load_q == FSP_LOAD_WAIT) && nvValid |=> running && (setting_q == $past(nvData));
    endproperty
    a_load_byte: assert property (p_load_byte) else $error("Stored byte not loaded");

    property p_ack_pulse;
        @(posedge ref_clk) disable iff (!rstn)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("Ack held too long");

    property p_setting_source;
        @(posedge ref_clk) disable iff (!rstn)
        ranPrev_q && $changed(setting_q) |-> $past(wrProt && guardAccept);
    endproperty
    a_setting_source: assert property (p_setting_source) else $error("Stray change");

    property p_nv_drop;
        @(posedge ref_clk) disable iff (!rstn)
        nvReq && nvValid |=> !nvReq;
    endproperty
    a_nv_drop: assert property (p_nv_drop) else $error("Load request held");

    property p_irq_level;
        @(posedge ref_clk) disable iff (!rstn)
        irq == |(status_q & enable_q);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt level wrong");

    property p_mass_erase;
        @(posedge ref_clk) disable iff (!rstn)
        cmdValid && cmdMassErase && (fsp_scen(setting_q) != FSP_SCEN_OPEN)
            |-> ##2 protViolation;
    endproperty
    a_mass_erase: assert property (p_mass_erase) else $error("Mass erase not flagged");
endmodule

// ---- test/fsp_nv_model.sv ----
// Behavioural stored-byte read port of the program array.
// Assumes one request per reset release; answers after lagCycles edges.
`timescale 1ns/1ps
module fsp_nv_model (
    input wire logic ref_clk,
    input wire logic nvReq,
    input wire logic [15:0] nvAddr,
    input wire logic [7:0] storedByte,
    input wire logic [3:0] lagCycles,
    output logic [7:0] nvData,
    output logic nvValid
);
    logic [3:0] lagQ;

    initial begin
        nvData = 8'h5A;
        nvValid = 1'b0;
        lagQ = 4'h0;
    end

    // Idle data toggles so a stale byte can never pass for a load
    always @(posedge ref_clk) begin
        nvValid <= 1'b0;
        nvData <= ~nvData;
        if (nvReq && !nvValid) begin
            if (lagQ == lagCycles && nvAddr == 16'hFF0D) begin
                nvValid <= 1'b1;
                nvData <= storedByte;
                lagQ <= 4'h0;
            end else begin
                lagQ <= lagQ + 4'h1;
            end
        end else if (!nvReq) begin
            lagQ <= 4'h0;
        end
    end
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the flash sector protection control.
// Assumes the stored-byte model answers each load request.
`timescale 1ns/1ps
module tb_top;
    import fsp_pkg::*;
    logic ref_clk, rstn, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic [7:0] wb_adr_i, nvData, storedByte;
    logic [31:0] wb_dat_i, wb_dat_o, rdv;
    logic [3:0] wb_sel_i, lagCycles;
    logic nvReq, nvValid, cmdValid, cmdMassErase, protViolation, irq;
    logic [15:0] nvAddr, cmdAddr;
    int errTotal = 0;
    int checkCount = 0;
    logic [7:0] okRow [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
    // {setting, address, mass erase, violation expected}
    logic [25:0] cases [24] = '{
        {8'hC7, 16'hF800, 2'h1}, {8'hC7, 16'hF7FF, 2'h0}, {8'hCF, 16'hF000, 2'h1},
        {8'hCF, 16'hEFFF, 2'h0}, {8'hD7, 16'hE000, 2'h1}, {8'hD7, 16'hDFFF, 2'h0},
        {8'hDF, 16'hC000, 2'h1}, {8'hDF, 16'hBFFF, 2'h0}, {8'hF8, 16'h41FF, 2'h1},
        {8'hF8, 16'h4200, 2'h0}, {8'hF8, 16'h3FFF, 2'h0}, {8'hF9, 16'h43FF, 2'h1},
        {8'hF9, 16'h4400, 2'h0}, {8'hFA, 16'h47FF, 2'h1}, {8'hFA, 16'h4800, 2'h0},
        {8'hFB, 16'h4FFF, 2'h1}, {8'hFB, 16'h5000, 2'h0}, {8'hFF, 16'h1234, 2'h0},
        {8'hFF, 16'h1234, 2'h2}, {8'hF8, 16'h1234, 2'h3}, {8'h7F, 16'h0000, 2'h1},
        {8'h47, 16'hF800, 2'h0}, {8'h47, 16'hF7FF, 2'h1}, {8'h78, 16'h4200, 2'h1}};

    fsp_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .nvReq(nvReq), .nvAddr(nvAddr), .nvData(nvData),
        .nvValid(nvValid), .cmdValid(cmdValid), .cmdMassErase(cmdMassErase),
        .cmdAddr(cmdAddr), .protViolation(protViolation), .irq(irq));

    fsp_nv_model i_nv (.ref_clk(ref_clk), .nvReq(nvReq), .nvAddr(nvAddr),
        .storedByte(storedByte), .lagCycles(lagCycles), .nvData(nvData),
        .nvValid(nvValid));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            errTotal++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Classic cycle: request held until ack is sampled, then one idle cycle
    task automatic wb(input logic we, input logic [3:0] sel, input logic [7:0] adr,
                      input logic [31:0] wd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        // No limit here: only the watchdog ends a wait for ack
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1);
        chk("ackCycles", 32'h0000_0002, n);
        rdv = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        wb(1'b1, 4'hF, adr, {24'h00_0000, d});
    endtask

    task automatic rd(input logic [7:0] adr);
        wb(1'b0, 4'hF, adr, 32'h0000_0000);
    endtask

    task automatic do_reset(input logic [7:0] s, input logic [3:0] lag, input int hold);
        int n;
        n = 0;
        storedByte <= s;
        lagCycles <= lag;
        rstn <= 1'b0;
        repeat (hold) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        while (nvReq !== 1'b0) begin
            @(posedge ref_clk);
            n++;
        end
        chk("loadDone", 32'h0000_0000, {31'h0, nvReq});
        chk("loadCycles", {28'h000_0000, lag} + 32'h0000_0002, n);
    endtask

    task automatic cmd(input logic [15:0] a, input logic m);
        cmdValid <= 1'b1;
        cmdAddr <= a;
        cmdMassErase <= m;
        @(posedge ref_clk);
        cmdValid <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask

    // Spare bit 6 kept erased in every setting the bench writes
    function automatic logic [7:0] mk(input logic [2:0] s);
        mk = {s[2], 1'b1, s[1], 2'b11, s[0], 2'b11};
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_load();
        do_reset(8'hC7, 4'h3, 7);
        chk("nvAddr", 32'h0000_FF0D, {16'h0000, nvAddr});
        rd(FSP_OFS_PROT);
        chk("loadedSetting", 32'h0000_00C7, rdv);
        // Byte lane 0 not selected: even a legal move must be ignored
        wb(1'b1, 4'hE, FSP_OFS_PROT, 32'h0000_007F);
        rd(FSP_OFS_PROT);
        chk("selGuard", 32'h0000_00C7, rdv);
        rd(8'h10);
        chk("unmapped", 32'h0000_0000, rdv);
        wr(FSP_OFS_STATUS, 8'hFF);
        rd(FSP_OFS_STATUS);
        chk("statusRo", 32'h0000_0000, rdv);
        $display("test load done");
    endtask

    task automatic t_trans();
        logic [2:0] eff;
        logic ok;
        for (int f = 0; f < 8; f++) begin
            for (int t = 0; t < 8; t++) begin
                do_reset(mk(f[2:0]), f[3:0], 2);
                eff = {f[2] & t[2], t[1:0]};
                ok = okRow[f][eff];
                wr(FSP_OFS_PROT, mk(t[2:0]));
                rd(FSP_OFS_PROT);
                chk("scenario", {24'h00_0000, ok ? mk(eff) : mk(f[2:0])}, rdv);
                rd(FSP_OFS_STATUS);
                chk("rejectFlag", {31'h0, !ok}, {31'h0, rdv[1]});
            end
        end
        $display("test transitions done");
    endtask

    task automatic t_size();
        logic [7:0] seq [6] = '{8'hEE, 8'hCE, 8'hD6, 8'hC8, 8'hCB, 8'hFF};
        logic [7:0] exp [6] = '{8'hEE, 8'hCE, 8'hCE, 8'hC8, 8'hC8, 8'hC8};
        do_reset(8'hFF, 4'h0, 2);
        for (int i = 0; i < 6; i++) begin
            wr(FSP_OFS_PROT, seq[i]);
            rd(FSP_OFS_PROT);
            chk("sizeLock", {24'h00_0000, exp[i]}, rdv);
        end
        do_reset(8'h5F, 4'h1, 2);
        wr(FSP_OFS_PROT, 8'hFF);
        rd(FSP_OFS_PROT);
        chk("polarityOneWay", 32'h0000_007F, rdv);
        $display("test size lock done");
    endtask

    task automatic t_addr();
        for (int i = 0; i < 24; i++) begin
            do_reset(cases[i][25:18], 4'h0, 2);
            wr(FSP_OFS_ENABLE, 8'h01);
            cmd(cases[i][17:2], cases[i][1]);
            chk("violation", {31'h0, cases[i][0]}, {31'h0, protViolation});
            chk("irq", {31'h0, cases[i][0]}, {31'h0, irq});
        end
        wr(FSP_OFS_ENABLE, 8'h00);
        cmd(16'h0000, 1'b1);
        chk("maskedIrq", 32'h0000_0000, {31'h0, irq});
        wr(FSP_OFS_ENABLE, 8'h01);
        chk("unmaskedIrq", 32'h0000_0001, {31'h0, irq});
        rd(FSP_OFS_ENABLE);
        chk("enableRead", 32'h0000_0001, rdv);
        wr(FSP_OFS_CLEAR, 8'h01);
        chk("clearedFlag", 32'h0000_0000, {31'h0, protViolation});
        chk("clearedIrq", 32'h0000_0000, {31'h0, irq});
        $display("test address checks done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        #200_000;
        errTotal++;
        $display("FAIL watchdog expected finish seen hang");
        give_verdict();
    end

    initial begin
        rstn = 1'b0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0000_0000;
        wb_sel_i = 4'hF;
        wb_we_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        cmdValid = 1'b0;
        cmdMassErase = 1'b0;
        cmdAddr = 16'h0000;
        storedByte = 8'hFF;
        lagCycles = 4'h0;
        @(posedge ref_clk);
        t_load();
        t_trans();
        t_size();
        t_addr();
        give_verdict();
    end
endmodule
